// ### adc_model.sv
// Purpose: Behavioural converter answering each start
// Assumes: One conversion outstanding
// Notes:   Data line toggles when not valid
`timescale 1ns/10ps
module adc_model (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        rst_in,
    // Converter
    input  wire        adc_start_in,
    input  wire [1:0]  adc_chan_in,
    input  wire [63:0] chan_vals_in,
    input  wire [3:0]  lat_in,
    output reg         adc_done_out = 1'b0,
    output reg  [15:0] adc_data_out = 16'h0
);
    reg [3:0] cnt_r  = 4'h0;
    reg       busy_r = 1'b0;
    always @(posedge core_clk_in) begin
        adc_done_out <= 1'b0;
        adc_data_out <= ~adc_data_out;
        if (rst_in)
            busy_r <= 1'b0;
        else if (adc_start_in) begin
            busy_r <= 1'b1;
            cnt_r  <= lat_in;
        end else if (busy_r && cnt_r == 4'h0) begin
            busy_r       <= 1'b0;
            adc_done_out <= 1'b1;
            adc_data_out <= chan_vals_in[adc_chan_in*16 +: 16];
        end else
            cnt_r <= cnt_r - 4'h1;
    end
endmodule // adc_model

// ### battery_measure_defines.vh
// Purpose: Shared constants for the battery measurement controller
// Assumes: 40 MHz core clock, 32-bit register bus
// Notes:   Register constants are word indices, taken from address bits [6:2]
`ifndef BATTERY_MEASURE_DEFINES_VH
`define BATTERY_MEASURE_DEFINES_VH
////////////////////////////////////////////////////////////////////////
// Timing
`define CLK_HZ          40000000
`define MEAS_PERIOD_MS  500
`define MEAS_PERIOD_CYC (`CLK_HZ / 1000 * `MEAS_PERIOD_MS)
`define AZ_UNIT_MS      500
`define AZ_UNIT_CYC     (`CLK_HZ / 1000 * `AZ_UNIT_MS)
////////////////////////////////////////////////////////////////////////
// Converter
`define CH_VOLT         2'h0
`define CH_CURR         2'h1
`define CH_TEMP         2'h2
`define CH_AZ           2'h3
`define RES_11          5'h0b
`define CUR_LSB_UV      9150
`define CUR_MAX         32'sh00003fff
`define CUR_MIN         -32'sh00004000
`define DIV_CUR         2'h0
`define DIV_VOLT        2'h1
`define DIV_PATH        2'h2
`define DIV_CUR_VAL     16384
`define DIV_VOLT_VAL    2048
`define DIV_PATH_VAL    65535
////////////////////////////////////////////////////////////////////////
// Modes
`define MODE_RUN        2'h0
`define MODE_SAMPLE     2'h1
`define MODE_SLEEP      2'h2
////////////////////////////////////////////////////////////////////////
// Word indices of registers
`define IX_CTRL         5'h00
`define IX_STATUS       5'h01
`define IX_ZERO_ZONE    5'h02
`define IX_CUR_OFF      5'h03
`define IX_CUR_GAIN     5'h04
`define IX_AZ_OFF       5'h05
`define IX_AZ_INT       5'h06
`define IX_PATH_RES     5'h07
`define IX_V_OFF        5'h08
`define IX_V_GAIN       5'h09
`define IX_IT_GAIN      5'h0a
`define IX_IT_OFF       5'h0b
`define IX_ET_GAIN      5'h0c
`define IX_ET_OFF       5'h0d
`define IX_RUN_THR      5'h0e
`define IX_SAMP_DIV     5'h0f
`define IX_NEAR_FULL    5'h10
`define IX_NEAR_EMPTY   5'h11
`define IX_SLEEP_V      5'h12
`define IX_LIST0        5'h13
`define IX_CFG_LAST     5'h16
`define IX_CUR_MA       5'h17
`define IX_PACK_MV      5'h18
`define IX_REPORT_MV    5'h19
`define IX_TEMP         5'h1a
`define IX_CHARGE       5'h1b
////////////////////////////////////////////////////////////////////////
// Control fields and reset values
`define CTRL_AZ_EN      0
`define CTRL_SAMP_EN    1
`define CTRL_EXT_TEMP   2
`define CTRL_WAKE       3
`define CTRL_WAKE_MASK  16'hfff7
`define RST_CTRL        16'h0e03
`define RST_ZERO_ZONE   16'h0003
`define RST_GAIN_CUR    16'h4000
`define RST_GAIN_11     16'h0800
`define RST_AZ_INT      16'h0010
`define RST_RUN_THR     16'h0014
`define RST_SAMP_DIV    16'h0010
`define RST_NEAR_FULL   16'h3a98
`define RST_NEAR_EMPTY  16'h2710
`define RST_SLEEP_V     16'h1f40
`define RST_LIST_VOLT   16'h4084
`define RST_LIST_CURR   16'h6191
`define RST_LIST_SAMP   16'h3021
`endif

// ### battery_measure_mode_ctrl.v
// Purpose: Measurement sequencer, calibration and Run/Sample/Sleep control
// Assumes: Converter answers each start with one done pulse
// Notes:   Avalon-MM slave, one wait cycle per access
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`include "battery_measure_defines.vh"
`timescale 1ns/10ps
module battery_measure_mode_ctrl #(
    parameter [31:0] MEAS_PERIOD_CYC = `MEAS_PERIOD_CYC,
    parameter [31:0] AZ_UNIT_CYC     = `AZ_UNIT_CYC
) (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        rst_in,
    // Avalon-MM slave
    input  wire [7:0]  address_in,
    input  wire        read_in,
    input  wire        write_in,
    input  wire [31:0] writedata_in,
    input  wire [3:0]  byteenable_in,
    output reg  [31:0] readdata_out,
    output reg         waitrequest_out,
    // Converter
    output reg         adc_start_out,
    output reg  [1:0]  adc_chan_out,
    output reg  [4:0]  adc_bits_out,
    output reg         adc_short_out,
    output reg         adc_ext_temp_out,
    input  wire        adc_done_in,
    input  wire [15:0] adc_data_in,
    // Status
    output reg  [1:0]  mode_out,
    output reg         calc_tick_out
);
    localparam S_IDLE  = 3'h0;
    localparam S_NEXT  = 3'h1;
    localparam S_START = 3'h2;
    localparam S_WAIT  = 3'h3;
    localparam S_CAL   = 3'h4;
    localparam S_STORE = 3'h5;
    localparam S_COMP  = 3'h6;
    localparam S_CSTO  = 3'h7;

    reg        [15:0] cfg_r [0:22];
    reg        [2:0]  st_r;
    reg        [1:0]  mode_r;
    reg        [1:0]  chan_r;
    reg        [15:0] list_r;
    reg        [2:0]  slot_r;
    reg        [1:0]  list_sel_r;
    reg        [31:0] per_cnt_r;
    reg        [31:0] hs_cnt_r;
    reg        [15:0] az_cnt_r;
    reg               az_due_r;
    reg        [15:0] samp_cnt_r;
    reg               trans_cnt_r;
    reg signed [31:0] raw_r;
    reg signed [31:0] cur_r;
    reg signed [31:0] pack_r;
    reg signed [31:0] report_r;
    reg signed [31:0] temp_r;
    reg signed [31:0] charge_r;
    reg signed [31:0] cal_raw;
    reg signed [15:0] cal_oa;
    reg signed [15:0] cal_ob;
    reg        [15:0] cal_gain;
    reg        [1:0]  cal_div;
    reg        [31:0] rd_val;
    reg        [15:0] wr_val;
    wire signed [31:0] cal_res;
    wire signed [31:0] cal_abs;
    wire              per_tick;
    wire              hs_tick;
    wire       [4:0]  idx;
    wire              above;
    wire              ext_sel;
    wire signed [31:0] adc_sx;
    integer           i;

    assign idx      = address_in[6:2];
    assign per_tick = (per_cnt_r == MEAS_PERIOD_CYC - 32'h1);
    assign hs_tick  = (hs_cnt_r == AZ_UNIT_CYC - 32'h1);
    assign ext_sel  = cfg_r[`IX_CTRL][`CTRL_EXT_TEMP];
    assign cal_abs  = cal_res[31] ? -cal_res : cal_res;
    assign above    = (cal_abs > $signed({16'h0, cfg_r[`IX_RUN_THR]}));
    assign adc_sx   = {{16{adc_data_in[15]}}, adc_data_in};

    function [15:0] def_val;
        input [4:0] n;
        begin
            case (n)
                `IX_CTRL:       def_val = `RST_CTRL;
                `IX_ZERO_ZONE:  def_val = `RST_ZERO_ZONE;
                `IX_CUR_GAIN:   def_val = `RST_GAIN_CUR;
                `IX_AZ_INT:     def_val = `RST_AZ_INT;
                `IX_V_GAIN:     def_val = `RST_GAIN_11;
                `IX_IT_GAIN:    def_val = `RST_GAIN_11;
                `IX_ET_GAIN:    def_val = `RST_GAIN_11;
                `IX_RUN_THR:    def_val = `RST_RUN_THR;
                `IX_SAMP_DIV:   def_val = `RST_SAMP_DIV;
                `IX_NEAR_FULL:  def_val = `RST_NEAR_FULL;
                `IX_NEAR_EMPTY: def_val = `RST_NEAR_EMPTY;
                `IX_SLEEP_V:    def_val = `RST_SLEEP_V;
                5'h13:          def_val = `RST_LIST_VOLT;
                5'h14:          def_val = `RST_LIST_CURR;
                5'h15:          def_val = `RST_LIST_VOLT;
                5'h16:          def_val = `RST_LIST_SAMP;
                default:        def_val = 16'h0000;
            endcase
        end
    endfunction

    // Thermistor table, tenths of kelvin
    function [15:0] ntc_lut;
        input [2:0] v;
        begin
            case (v)
                3'h0:    ntc_lut = 16'h0a28;
                3'h1:    ntc_lut = 16'h0b0e;
                3'h2:    ntc_lut = 16'h0b72;
                3'h3:    ntc_lut = 16'h0bd6;
                3'h4:    ntc_lut = 16'h0c3a;
                3'h5:    ntc_lut = 16'h0c9e;
                3'h6:    ntc_lut = 16'h0d02;
                default: ntc_lut = 16'h0d66;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Calibration operand select
    always @* begin
        cal_raw  = raw_r;
        cal_oa   = 16'sh0000;
        cal_ob   = 16'sh0000;
        cal_gain = cfg_r[`IX_V_GAIN];
        cal_div  = `DIV_VOLT;
        if (st_r == S_COMP || st_r == S_CSTO) begin
            cal_raw  = cur_r;
            cal_gain = cfg_r[`IX_PATH_RES];
            cal_div  = `DIV_PATH;
        end else begin
            case (chan_r)
                `CH_CURR: begin
                    cal_oa   = cfg_r[`IX_CUR_OFF];
                    cal_ob   = cfg_r[`IX_AZ_OFF];
                    cal_gain = cfg_r[`IX_CUR_GAIN];
                    cal_div  = `DIV_CUR;
                end
                `CH_TEMP: begin
                    cal_oa   = ext_sel ? cfg_r[`IX_ET_OFF] : cfg_r[`IX_IT_OFF];
                    cal_gain = ext_sel ? cfg_r[`IX_ET_GAIN] : cfg_r[`IX_IT_GAIN];
                end
                default: begin
                    cal_oa = cfg_r[`IX_V_OFF];
                end
            endcase
        end
    end

    cal_unit u_cal (
        .core_clk_in (core_clk_in),
        .raw_in      (cal_raw),
        .off_a_in    (cal_oa),
        .off_b_in    (cal_ob),
        .gain_in     (cal_gain),
        .div_sel_in  (cal_div),
        .result_out  (cal_res)
    );

    ////////////////////////////////////////////////////////////////////
    // Read mux and write merge
    always @* begin
        rd_val = 32'h0;
        if (idx == `IX_STATUS)
            rd_val = {27'h0, list_sel_r, (st_r != S_IDLE), mode_r};
        else if (idx <= `IX_CFG_LAST)
            rd_val = {16'h0, cfg_r[idx]};
        else if (idx == `IX_CUR_MA)
            rd_val = cur_r;
        else if (idx == `IX_PACK_MV)
            rd_val = pack_r;
        else if (idx == `IX_REPORT_MV)
            rd_val = report_r;
        else if (idx == `IX_TEMP)
            rd_val = temp_r;
        else if (idx == `IX_CHARGE)
            rd_val = charge_r;
        wr_val = cfg_r[idx <= `IX_CFG_LAST ? idx : 5'h0];
        if (byteenable_in[0])
            wr_val[7:0] = writedata_in[7:0];
        if (byteenable_in[1])
            wr_val[15:8] = writedata_in[15:8];
    end

    ////////////////////////////////////////////////////////////////////
    // Registers, bus and sequencer
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            for (i = 0; i <= 22; i = i + 1)
                cfg_r[i] <= def_val(i[4:0]);
            readdata_out     <= 32'h0;
            waitrequest_out  <= 1'b1;
            adc_start_out    <= 1'b0;
            adc_chan_out     <= `CH_VOLT;
            adc_bits_out     <= `RES_11;
            adc_short_out    <= 1'b0;
            adc_ext_temp_out <= 1'b0;
            mode_out         <= `MODE_RUN;
            calc_tick_out    <= 1'b0;
            st_r             <= S_IDLE;
            mode_r           <= `MODE_RUN;
            chan_r           <= `CH_VOLT;
            list_r           <= 16'h0;
            slot_r           <= 3'h0;
            list_sel_r       <= 2'h1;
            per_cnt_r        <= 32'h0;
            hs_cnt_r         <= 32'h0;
            az_cnt_r         <= 16'h0;
            az_due_r         <= 1'b0;
            samp_cnt_r       <= 16'h0;
            trans_cnt_r      <= 1'b0;
            raw_r            <= 32'sh0;
            cur_r            <= 32'sh0;
            pack_r           <= 32'sh0;
            report_r         <= 32'sh0;
            temp_r           <= 32'sh0;
            charge_r         <= 32'sh0;
        end else begin
            adc_start_out <= 1'b0;
            calc_tick_out <= per_tick;
            mode_out      <= mode_r;
            per_cnt_r     <= per_tick ? 32'h0 : per_cnt_r + 32'h1;
            hs_cnt_r      <= hs_tick ? 32'h0 : hs_cnt_r + 32'h1;
            // Avalon access, answered one cycle after it is seen
            waitrequest_out <= ~(waitrequest_out & (read_in | write_in));
            if (waitrequest_out)
                readdata_out <= rd_val;
            if (write_in && !waitrequest_out && idx <= `IX_CFG_LAST && idx != `IX_STATUS) begin
                if (idx == `IX_CTRL)
                    cfg_r[idx] <= wr_val & `CTRL_WAKE_MASK;
                else
                    cfg_r[idx] <= wr_val;
                if (idx == `IX_CTRL && wr_val[`CTRL_WAKE] && mode_r == `MODE_SLEEP) begin
                    mode_r      <= `MODE_RUN;
                    trans_cnt_r <= 1'b0;
                end
            end
            if (hs_tick && cfg_r[`IX_CTRL][`CTRL_AZ_EN]) begin
                if (az_cnt_r + 16'h1 >= cfg_r[`IX_AZ_INT]) begin
                    az_cnt_r <= 16'h0;
                    az_due_r <= 1'b1;
                end else begin
                    az_cnt_r <= az_cnt_r + 16'h1;
                end
            end
            if (per_tick) begin
                charge_r <= charge_r + cur_r;
                if (mode_r != `MODE_SAMPLE || samp_cnt_r + 16'h1 >= cfg_r[`IX_SAMP_DIV])
                    samp_cnt_r <= 16'h0;
                else
                    samp_cnt_r <= samp_cnt_r + 16'h1;
            end
            case (st_r)
                S_IDLE: begin
                    adc_short_out <= 1'b0;
                    if (per_tick && mode_r != `MODE_SLEEP && (mode_r == `MODE_RUN || samp_cnt_r == 16'h0)) begin
                        if (mode_r == `MODE_SAMPLE) begin
                            list_sel_r <= 2'h3;
                            list_r     <= cfg_r[`IX_LIST0 + 5'h3];
                        end else if (pack_r > $signed({16'h0, cfg_r[`IX_NEAR_FULL]})) begin
                            list_sel_r <= 2'h0;
                            list_r     <= cfg_r[`IX_LIST0];
                        end else if (pack_r < $signed({16'h0, cfg_r[`IX_NEAR_EMPTY]})) begin
                            list_sel_r <= 2'h2;
                            list_r     <= cfg_r[`IX_LIST0 + 5'h2];
                        end else begin
                            list_sel_r <= 2'h1;
                            list_r     <= cfg_r[`IX_LIST0 + 5'h1];
                        end
                        slot_r <= 3'h0;
                        if (az_due_r && !(hs_tick && cfg_r[`IX_CTRL][`CTRL_AZ_EN] &&
                                          az_cnt_r + 16'h1 >= cfg_r[`IX_AZ_INT]))
                            az_due_r <= 1'b0;
                        if (az_due_r) begin
                            chan_r <= `CH_AZ;
                            st_r   <= S_START;
                        end else begin
                            st_r <= S_NEXT;
                        end
                    end
                end
                S_NEXT: begin
                    adc_short_out <= 1'b0;
                    if (slot_r >= list_r[14:12] || slot_r > 3'h5) begin
                        st_r <= S_IDLE;
                    end else begin
                        chan_r <= list_r[{slot_r, 1'b0} +: 2];
                        slot_r <= slot_r + 3'h1;
                        st_r   <= S_START;
                    end
                end
                S_START: begin
                    adc_start_out    <= 1'b1;
                    adc_chan_out     <= chan_r;
                    adc_ext_temp_out <= ext_sel;
                    adc_short_out    <= (chan_r == `CH_AZ);
                    if (chan_r == `CH_VOLT || chan_r == `CH_TEMP)
                        adc_bits_out <= `RES_11;
                    else
                        adc_bits_out <= cfg_r[`IX_CTRL][12:8];
                    st_r <= S_WAIT;
                end
                S_WAIT: begin
                    if (adc_done_in) begin
                        if (chan_r == `CH_AZ) begin
                            cfg_r[`IX_AZ_OFF] <= adc_data_in;
                            st_r              <= S_NEXT;
                        end else begin
                            if (chan_r == `CH_CURR && adc_sx > `CUR_MAX)
                                raw_r <= `CUR_MAX;
                            else if (chan_r == `CH_CURR && adc_sx < `CUR_MIN)
                                raw_r <= `CUR_MIN;
                            else
                                raw_r <= adc_sx;
                            st_r <= S_CAL;
                        end
                    end
                end
                S_CAL: begin
                    st_r <= S_STORE;
                end
                S_STORE: begin
                    st_r <= S_NEXT;
                    case (chan_r)
                        `CH_CURR: begin
                            if (cal_abs < $signed({16'h0, cfg_r[`IX_ZERO_ZONE]}))
                                cur_r <= 32'sh0;
                            else
                                cur_r <= cal_res;
                            if (mode_r == `MODE_SAMPLE && above) begin
                                trans_cnt_r <= ~trans_cnt_r;
                                if (trans_cnt_r)
                                    mode_r <= `MODE_RUN;
                            end else if (mode_r == `MODE_RUN && !above &&
                                         cfg_r[`IX_CTRL][`CTRL_SAMP_EN]) begin
                                trans_cnt_r <= ~trans_cnt_r;
                                if (trans_cnt_r)
                                    mode_r <= `MODE_SAMPLE;
                            end else begin
                                trans_cnt_r <= 1'b0;
                            end
                        end
                        `CH_TEMP: begin
                            if (ext_sel)
                                temp_r <= {16'h0, ntc_lut(cal_res[10:8])};
                            else
                                temp_r <= cal_res;
                        end
                        default: begin
                            pack_r <= cal_res;
                            st_r   <= S_COMP;
                            if (mode_r == `MODE_SAMPLE &&
                                cal_res < $signed({16'h0, cfg_r[`IX_SLEEP_V]})) begin
                                mode_r      <= `MODE_SLEEP;
                                trans_cnt_r <= 1'b0;
                                st_r        <= S_IDLE;
                            end
                        end
                    endcase
                end
                S_COMP: begin
                    st_r <= S_CSTO;
                end
                default: begin
                    report_r <= pack_r + cal_res;
                    st_r     <= S_NEXT;
                end
            endcase
        end
    end
endmodule // battery_measure_mode_ctrl

// ### battery_measure_mode_ctrl_monitor.sv
// Purpose: Port checks for the measurement controller
// Assumes: One clock domain, reset synchronous high
// Notes:   Bound from the bench top file
`include "battery_measure_defines.vh"
`timescale 1ns/10ps
module bmm_monitor #(
    parameter [31:0] MEAS_PERIOD_CYC = 200
) (
    input wire       core_clk_in,
    input wire       rst_in,
    input wire       read_in,
    input wire       write_in,
    input wire       waitrequest_out,
    input wire       adc_start_out,
    input wire [1:0] adc_chan_out,
    input wire [4:0] adc_bits_out,
    input wire       adc_short_out,
    input wire       adc_done_in,
    input wire [1:0] mode_out,
    input wire       calc_tick_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    reg [31:0] gap_r;
    reg        seen_r;
    always @(posedge core_clk_in) begin
        gap_r  <= (rst_in || calc_tick_out) ? 32'h0 : gap_r + 32'h1;
        seen_r <= rst_in ? 1'b0 : (seen_r | calc_tick_out);
    end
    sequence one_wait; !waitrequest_out ##1 waitrequest_out; endsequence
    sequence quiet3; !adc_start_out [*3]; endsequence
    AST_BUS_ONE_WAIT: assert property ((read_in || write_in) && waitrequest_out |=> one_wait)
        else $error("bus wait not one cycle");
    AST_ELEVEN_BITS: assert property (adc_start_out && !adc_chan_out[0] |-> adc_bits_out == `RES_11)
        else $error("voltage or temperature not at 11 bits");
    AST_SHORT_AZ: assert property (adc_short_out |-> adc_chan_out == `CH_AZ)
        else $error("sense short outside auto-zero");
    AST_GAP_AFTER_DONE: assert property (adc_done_in |-> quiet3)
        else $error("start too soon after done");
    AST_PERIOD: assert property (calc_tick_out && seen_r |-> gap_r == MEAS_PERIOD_CYC - 32'h1)
        else $error("calc tick spacing wrong");
    AST_RUN_BATCH: assert property (calc_tick_out && mode_out == `MODE_RUN |-> ##[0:3] adc_start_out)
        else $error("no batch in run period");
    AST_SLEEP_FROM_SAMPLE: assert property ($changed(mode_out) && mode_out == `MODE_SLEEP |->
        $past(mode_out) == `MODE_SAMPLE)
        else $error("sleep entered not from sample");
    AST_SLEEP_IDLE: assert property (mode_out == `MODE_SLEEP |-> !adc_start_out)
        else $error("conversion in sleep");
endmodule // bmm_monitor

// ### cal_unit.v
// Purpose: Offset and gain calibration arithmetic, one cycle latency
// Assumes: Gain is unsigned, offsets and raw are signed
// Notes:   Signed quotient truncates toward zero
`include "battery_measure_defines.vh"
`timescale 1ns/10ps
module cal_unit (
    // Clock
    input  wire               core_clk_in,
    // Operands
    input  wire signed [31:0] raw_in,
    input  wire signed [15:0] off_a_in,
    input  wire signed [15:0] off_b_in,
    input  wire        [15:0] gain_in,
    input  wire        [1:0]  div_sel_in,
    // Result
    output reg  signed [31:0] result_out
);
    wire signed [33:0] diff;
    wire signed [55:0] prod;
    reg  signed [55:0] quot;
    assign diff = {{2{raw_in[31]}}, raw_in}
                - {{18{off_a_in[15]}}, off_a_in}
                - {{18{off_b_in[15]}}, off_b_in};
    assign prod = {{22{diff[33]}}, diff} * $signed({40'h0, gain_in});
    always @* begin
        case (div_sel_in)
            `DIV_CUR:  quot = prod / `DIV_CUR_VAL;
            `DIV_VOLT: quot = prod / `DIV_VOLT_VAL;
            default:   quot = prod / `DIV_PATH_VAL;
        endcase
    end
    always @(posedge core_clk_in) begin
        result_out <= quot[31:0];
    end
endmodule // cal_unit

// ### tb_battery_measure_mode_ctrl.sv
// Purpose: Self-checking bench for the measurement controller
// Assumes: Shortened period parameters
// Notes:   Bus tasks wait on waitrequest
`include "battery_measure_defines.vh"
`timescale 1ns/10ps
module tb_battery_measure_mode_ctrl;
    reg         core_clk_in  = 1'b0;
    reg         rst_in       = 1'b1;
    reg  [7:0]  address_in   = 8'h00;
    reg         read_in      = 1'b0;
    reg         write_in     = 1'b0;
    reg  [31:0] writedata_in = 32'h0;
    reg  [15:0] vraw         = 16'h2328;
    reg  [15:0] craw         = 16'h03e8;
    reg  [3:0]  lat          = 4'h1;
    reg  [31:0] rd_v;
    wire [31:0] readdata_out;
    wire        waitrequest_out, adc_start_out, adc_short_out, adc_ext_temp_out, adc_done_in, calc_tick_out;
    wire [1:0]  adc_chan_out, mode_out;
    wire [4:0]  adc_bits_out;
    wire [15:0] adc_data_in;
    integer     mismatches = 0, compares = 0, nstart = 0, nvolt = 0, s0;
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        if (!rst_in) begin
            nstart <= nstart + (adc_start_out && adc_chan_out != `CH_AZ);
            nvolt  <= nvolt + (adc_start_out && adc_chan_out == `CH_VOLT);
        end
    end
    battery_measure_mode_ctrl #(.MEAS_PERIOD_CYC(32'd200), .AZ_UNIT_CYC(32'd100)) dut (.byteenable_in(4'h3), .*);
    adc_model partner (.core_clk_in(core_clk_in), .rst_in(rst_in), .adc_start_in(adc_start_out),
        .adc_chan_in(adc_chan_out), .chan_vals_in({16'h0000, 16'h0400, craw, vraw}), .lat_in(lat),
        .adc_done_out(adc_done_in), .adc_data_out(adc_data_in));
    ////////////////////////////////////////////////////////////////
    task tally_and_finish; begin
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp); begin
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    end endtask
    task bus(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge core_clk_in);
            address_in   <= a;
            writedata_in <= d;
            read_in      <= !wr;
            write_in     <= wr;
            @(posedge core_clk_in);
            while (waitrequest_out !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge core_clk_in);
            end
            rd_v = readdata_out;
            read_in  <= 1'b0;
            write_in <= 1'b0;
            if (n == 20) begin
                mismatches = mismatches + 1;
                tally_and_finish;
            end
        end
    endtask
    task ticks(input integer k);
        integer n;
        begin
            n = 0;
            while (k > 0 && n < 2000) begin
                @(posedge core_clk_in);
                n = n + 1;
                if (calc_tick_out === 1'b1)
                    k = k - 1;
            end
            if (k > 0) begin
                mismatches = mismatches + 1;
                tally_and_finish;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        bus(0, 8'h08, 0);
        chk("zero_zone", rd_v, 32'h3);
        bus(0, 8'h10, 0);
        chk("cur_gain", rd_v, 32'h4000);
        bus(1, 8'h7c, 32'hffff);
        bus(0, 8'h7c, 0);
        chk("unmapped", rd_v, 32'h0);
        $display("test registers done");
        bus(1, 8'h0c, 3);
        bus(1, 8'h10, 32'h6000);
        bus(1, 8'h20, 100);
        bus(1, 8'h24, 32'h0c00);
        bus(1, 8'h1c, 32'h8000);
        bus(1, 8'h3c, 2);
        ticks(3);
        bus(0, 8'h5c, 0);
        chk("cur_ma", rd_v, 997 * 24576 / 16384);
        bus(0, 8'h60, 0);
        chk("pack_mv", rd_v, 8900 * 3072 / 2048);
        bus(0, 8'h64, 0);
        chk("report_mv", rd_v, 8900 * 3072 / 2048 + (997 * 24576 / 16384) * 32768 / 65535);
        bus(0, 8'h68, 0);
        chk("temp_int", rd_v, 1024 * 2048 / 2048);
        bus(0, 8'h6c, 0);
        s0 = rd_v;
        ticks(1);
        bus(0, 8'h6c, 0);
        chk("charge_step", rd_v - s0, 997 * 24576 / 16384);
        ticks(1);
        s0 = nstart;
        rd_v = nvolt;
        ticks(1);
        chk("volt_per_period", nvolt - rd_v, 2);
        chk("starts_per_period", nstart - s0, 6);
        chk("mode_run", mode_out, `MODE_RUN);
        $display("test calibration done");
        lat <= 4'h9;
        craw <= 16'h0004;
        ticks(2);
        bus(0, 8'h5c, 0);
        chk("zero_zone_ma", rd_v, 32'h0);
        chk("mode_sample", mode_out, `MODE_SAMPLE);
        ticks(1);
        s0 = nstart;
        ticks(4);
        chk("sample_starts", nstart - s0, 6);
        craw <= 16'h03e8;
        ticks(6);
        chk("mode_back_run", mode_out, `MODE_RUN);
        $display("test run sample done");
        craw <= 16'h0004;
        vraw <= 16'h1388;
        ticks(8);
        chk("mode_sleep", mode_out, `MODE_SLEEP);
        s0 = nstart;
        ticks(2);
        chk("sleep_starts", nstart - s0, 0);
        vraw <= 16'h2328;
        bus(1, 8'h00, 32'h0e0b);
        ticks(1);
        chk("mode_wake", mode_out, `MODE_RUN);
        $display("test sleep done");
        tally_and_finish;
    end
endmodule // tb_battery_measure_mode_ctrl
bind battery_measure_mode_ctrl bmm_monitor #(.MEAS_PERIOD_CYC(MEAS_PERIOD_CYC)) mon (.*);
